// ===== irb_pkg.sv
// Package with offsets, field positions and types of the infrared register bank
package irb_pkg;

  // Register offsets within a bank
  localparam logic [2:0] OFS_0 = 3'h0;
  localparam logic [2:0] OFS_1 = 3'h1;
  localparam logic [2:0] OFS_2 = 3'h2;
  localparam logic [2:0] OFS_3 = 3'h3;
  localparam logic [2:0] OFS_4 = 3'h4;
  localparam logic [2:0] OFS_6 = 3'h6;
  localparam logic [2:0] OFS_7 = 3'h7;

  // Bank numbers
  localparam logic [2:0] BANK_4 = 3'h4;
  localparam logic [2:0] BANK_5 = 3'h5;
  localparam logic [2:0] BANK_6 = 3'h6;
  localparam logic [2:0] BANK_7 = 3'h7;

  // Bank selector layout and codes
  localparam int          BSE_BIT       = 7;
  localparam logic [6:0]  BANK_CODE_0   = 7'h00;
  localparam logic [6:0]  BANK_CODE_1   = 7'h60;
  localparam logic [6:0]  BANK_CODE_2   = 7'h70;
  localparam logic [6:0]  BANK_CODE_3   = 7'h71;
  localparam logic [6:0]  BANK_CODE_4   = 7'h72;
  localparam logic [6:0]  BANK_CODE_5   = 7'h73;
  localparam logic [6:0]  BANK_CODE_6   = 7'h74;
  localparam logic [6:0]  BANK_CODE_7   = 7'h75;

  // Writable bit masks (reserved bits read zero)
  localparam logic [7:0] MASK_CTRL_ONE   = 8'h0c;
  localparam logic [7:0] MASK_CTRL_TWO   = 8'h13;
  localparam logic [7:0] MASK_CTRL_THREE = 8'hc0;
  localparam logic [7:0] MASK_PW         = 8'h0f;
  localparam logic [7:0] MASK_CFG_ONE    = 8'hff;
  localparam logic [7:0] MASK_CFG_THREE  = 8'h77;
  localparam logic [7:0] MASK_CFG_FOUR   = 8'hbc;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } irb_req_type;

  // Read-only demodulator and modulator inputs
  typedef struct packed {
    logic [2:0] demod_bandwidth;
    logic [4:0] demod_frequency;
    logic [2:0] carrier_pulse_width;
    logic [4:0] carrier_frequency;
    logic [7:0] consumer_ir_config;
  } irb_ro_type;

endpackage

// ===== irb_bank_decode.sv
// Bank selector decoder: maps a written selector byte to a bank number
`timescale 1ns/1ns
module irb_bank_decode
(
  // Selector byte and held bank
  input  wire logic [7:0] sel_byte,
  input  wire logic [2:0] bank_now,
  // Resulting bank
  output logic      [2:0] bank_out,
  output logic            bank_mode
);

  // Selector with top bit set picks a bank by its low seven bits
  always_comb
  begin
    bank_mode = sel_byte[irb_pkg::BSE_BIT];
    bank_out  = bank_now;
    if (!sel_byte[irb_pkg::BSE_BIT])
      bank_out = 3'h0;
    else if (sel_byte[6:0] == irb_pkg::BANK_CODE_2)
      bank_out = 3'h2;
    else if (sel_byte[6:0] == irb_pkg::BANK_CODE_3)
      bank_out = 3'h3;
    else if (sel_byte[6:0] == irb_pkg::BANK_CODE_4)
      bank_out = 3'h4;
    else if (sel_byte[6:0] == irb_pkg::BANK_CODE_5)
      bank_out = 3'h5;
    else if (sel_byte[6:0] == irb_pkg::BANK_CODE_6)
      bank_out = 3'h6;
    else if (sel_byte[6:0] == irb_pkg::BANK_CODE_7)
      bank_out = 3'h7;
    else if (sel_byte[6:5] == 2'h3)
      bank_out = 3'h1;
    else
      bank_out = 3'h1;
  end

endmodule

// ===== irb_pin_sync.sv
// Three-stage synchroniser with agreement filter for a group of pin inputs
`timescale 1ns/1ns
module irb_pin_sync
#(
  parameter int WIDTH = 24
)
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Asynchronous input and settled output
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // Synchroniser chain
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end
    else
    begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Accept a bit once the second and third stages agree
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pin_out <= '0;
    else
      pin_out <= (pin_out & ~(stage2_reg ^ stage3_reg))
               | (stage3_reg & ~(stage2_reg ^ stage3_reg));
  end

endmodule

// ===== irb_top.sv
// Banked register file for the infrared functions of the second serial port
// Notes on behaviour
// - Registers form eight banks of eight byte locations each.
// - Offsets 0 to 7 decode in every bank; selected bank picks the register except at offset 3.
// - Banks 0 to 3 are shared UART/IR; banks 4 to 7 hold IR registers only.
// - Line control/bank selector sits at offset 3 in every bank, read/write.
// - Writing offset 3 with bit 7 set makes bits 6-0 a bank code.
// - Software chooses one or both DMA channels for serial data.
// - Bank 7 offset 0 reads demodulator bandwidth and frequency, read-only.
// - Bank 7 offset 1 reads carrier pulse width and frequency, read-only.
// - Bank 6 offset 2 holds a 4-bit pulse width code, upper bits reserved.
// - Bank 7 offset 4 holds interface configuration: eight bits, all writable, none reserved.
// - Bank 7 offset 6 holds two 3-bit fields; bits 7 and 3 reserved.
`timescale 1ns/1ns
module irb_top
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Register port
  input  wire irb_pkg::irb_req_type req,
  output logic              [7:0] rdata,
  // Read-only status from the modulator logic (asynchronous)
  input  wire irb_pkg::irb_ro_type  ro_in,
  // Configuration outputs
  output logic              [2:0] active_bank,
  output logic              [6:0] line_control,
  output logic              [3:0] pulse_width_code,
  output logic              [7:0] ir_interface_config_one,
  output logic              [7:0] ir_interface_config_three,
  output logic              [7:0] ir_interface_config_four,
  output logic              [1:0] dma_channel_enable,
  // Bank 0-3 access strobe for the shared UART logic
  output logic                    uart_bank_access
);

  // Register storage
  logic [7:0] line_control_bank_select_reg;
  logic [2:0] bank_reg;
  logic [7:0] ir_control_one_reg;
  logic [7:0] ir_control_two_reg;
  logic [7:0] ir_control_three_reg;
  logic [7:0] slow_ir_pulse_width_reg;
  logic [7:0] cfg_one_reg;
  logic [7:0] cfg_three_reg;
  logic [7:0] cfg_four_reg;
  logic [1:0] dma_reg;
  logic [7:0] rdata_next;
  logic [2:0] bank_next;
  logic       bank_mode;
  logic [23:0] ro_sync;
  irb_pkg::irb_ro_type ro_s;
  logic       wr_sel;

  // Bring the read-only fields into the clock domain
  irb_pin_sync #(.WIDTH(24)) u_sync
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (ro_in),
    .pin_out (ro_sync)
  );
  assign ro_s = ro_sync;

  // Bank selection decoder
  irb_bank_decode u_dec
  (
    .sel_byte (req.wdata),
    .bank_now (bank_reg),
    .bank_out (bank_next),
    .bank_mode(bank_mode)
  );

  // Write to the selector is decoded in every bank
  assign wr_sel = req.wr && (req.addr == irb_pkg::OFS_3);

  // Masked write helper
  function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
    masked = d & m;
  endfunction

  // True when a write hits the given bank and offset
  function automatic logic hit(input logic [2:0] b, input logic [2:0] o,
                               input logic [2:0] cb, input logic [2:0] a);
    hit = (b == cb) && (a == o);
  endfunction

  // Line control and bank selector
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      line_control_bank_select_reg <= irb_pkg::RST_BYTE;
      bank_reg                     <= 3'h0;
    end
    else if (wr_sel)
    begin
      line_control_bank_select_reg <= req.wdata;
      bank_reg                     <= bank_next;
    end
  end

  // Bank 4 and 5 control registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ir_control_one_reg <= irb_pkg::RST_BYTE;
      ir_control_two_reg <= irb_pkg::RST_BYTE;
    end
    else if (req.wr)
    begin
      if (hit(irb_pkg::BANK_4, irb_pkg::OFS_2, bank_reg, req.addr))
        ir_control_one_reg <= masked(req.wdata, irb_pkg::MASK_CTRL_ONE);
      if (hit(irb_pkg::BANK_5, irb_pkg::OFS_4, bank_reg, req.addr))
        ir_control_two_reg <= masked(req.wdata, irb_pkg::MASK_CTRL_TWO);
    end
  end

  // Bank 6 registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ir_control_three_reg    <= irb_pkg::RST_BYTE;
      slow_ir_pulse_width_reg <= irb_pkg::RST_BYTE;
    end
    else if (req.wr)
    begin
      if (hit(irb_pkg::BANK_6, irb_pkg::OFS_0, bank_reg, req.addr))
        ir_control_three_reg <= masked(req.wdata, irb_pkg::MASK_CTRL_THREE);
      if (hit(irb_pkg::BANK_6, irb_pkg::OFS_2, bank_reg, req.addr))
        slow_ir_pulse_width_reg <= masked(req.wdata, irb_pkg::MASK_PW);
    end
  end

  // Bank 7 configuration registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cfg_one_reg   <= irb_pkg::RST_BYTE;
      cfg_three_reg <= irb_pkg::RST_BYTE;
      cfg_four_reg  <= irb_pkg::RST_BYTE;
    end
    else if (req.wr)
    begin
      if (hit(irb_pkg::BANK_7, irb_pkg::OFS_4, bank_reg, req.addr))
        cfg_one_reg <= masked(req.wdata, irb_pkg::MASK_CFG_ONE);
      if (hit(irb_pkg::BANK_7, irb_pkg::OFS_6, bank_reg, req.addr))
        cfg_three_reg <= masked(req.wdata, irb_pkg::MASK_CFG_THREE);
      if (hit(irb_pkg::BANK_7, irb_pkg::OFS_7, bank_reg, req.addr))
        cfg_four_reg <= masked(req.wdata, irb_pkg::MASK_CFG_FOUR);
    end
  end

  // DMA channel enables, held in bank 5 offset 7
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dma_reg <= 2'h0;
    else if (req.wr && hit(irb_pkg::BANK_5, irb_pkg::OFS_7, bank_reg, req.addr))
      dma_reg <= req.wdata[1:0];
  end

  // Read multiplexer; reserved locations return zero
  always_comb
  begin
    rdata_next = 8'h00;
    if (req.addr == irb_pkg::OFS_3)
      rdata_next = line_control_bank_select_reg;
    else if (bank_reg == irb_pkg::BANK_4 && req.addr == irb_pkg::OFS_2)
      rdata_next = ir_control_one_reg;
    else if (bank_reg == irb_pkg::BANK_5 && req.addr == irb_pkg::OFS_4)
      rdata_next = ir_control_two_reg;
    else if (bank_reg == irb_pkg::BANK_5 && req.addr == irb_pkg::OFS_7)
      rdata_next = {6'h00, dma_reg};
    else if (bank_reg == irb_pkg::BANK_6 && req.addr == irb_pkg::OFS_0)
      rdata_next = ir_control_three_reg;
    else if (bank_reg == irb_pkg::BANK_6 && req.addr == irb_pkg::OFS_2)
      rdata_next = slow_ir_pulse_width_reg;
    else if (bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_0)
      rdata_next = {ro_s.demod_bandwidth, ro_s.demod_frequency};
    else if (bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_1)
      rdata_next = {ro_s.carrier_pulse_width, ro_s.carrier_frequency};
    else if (bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_2)
      rdata_next = ro_s.consumer_ir_config;
    else if (bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_4)
      rdata_next = cfg_one_reg;
    else if (bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_6)
      rdata_next = cfg_three_reg;
    else if (bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_7)
      rdata_next = cfg_four_reg;
  end

  // Registered read data, valid the cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (req.rd)
      rdata <= rdata_next;
    else
      rdata <= 8'h00;
  end

  // Registered configuration outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      active_bank               <= 3'h0;
      line_control              <= 7'h00;
      pulse_width_code          <= 4'h0;
      ir_interface_config_one   <= 8'h00;
      ir_interface_config_three <= 8'h00;
      ir_interface_config_four  <= 8'h00;
      dma_channel_enable        <= 2'h0;
      uart_bank_access          <= 1'b0;
    end
    else
    begin
      active_bank               <= bank_reg;
      line_control              <= line_control_bank_select_reg[irb_pkg::BSE_BIT-1:0];
      pulse_width_code          <= slow_ir_pulse_width_reg[3:0];
      ir_interface_config_one   <= cfg_one_reg;
      ir_interface_config_three <= cfg_three_reg;
      ir_interface_config_four  <= cfg_four_reg;
      dma_channel_enable        <= dma_reg;
      // Banks 0-3 are served by the shared UART logic, except offset 3 which is the selector
      uart_bank_access          <= (req.wr || req.rd) && !bank_reg[2]
                                   && (req.addr != irb_pkg::OFS_3);
    end
  end

  // Bank selector checks
  a_sel_write_bank: assert property (@(posedge clk_sys) disable iff (rst)
    wr_sel && bank_mode && req.wdata[6:0] == irb_pkg::BANK_CODE_7
    |=> bank_reg == irb_pkg::BANK_7) else $error("bank 7 not selected");
  a_sel_clear_bank: assert property (@(posedge clk_sys) disable iff (rst)
    wr_sel && !bank_mode
    |=> bank_reg == 3'h0) else $error("bank 0 not selected");
  a_sel_held_value: assert property (@(posedge clk_sys) disable iff (rst)
    wr_sel
    |=> line_control_bank_select_reg == $past(req.wdata))
    else $error("selector write");
  a_sel_any_bank: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && req.addr == irb_pkg::OFS_3
    |=> rdata == $past(line_control_bank_select_reg)) else $error("selector read");

  // Reserved bits stay clear
  a_pw_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    slow_ir_pulse_width_reg[7:4] == 4'h0) else $error("pulse width reserved set");
  a_cfg3_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_three_reg[7] == 1'b0 && cfg_three_reg[3] == 1'b0)
    else $error("config three reserved set");

  // Read path
  a_demod_read: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_0
    |=> rdata == {$past(ro_s.demod_bandwidth), $past(ro_s.demod_frequency)})
    else $error("demod read");
  a_mod_read: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_1
    |=> rdata == {$past(ro_s.carrier_pulse_width), $past(ro_s.carrier_frequency)})
    else $error("modulator read");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && bank_reg == irb_pkg::BANK_7 && req.addr == 3'h5 |=> rdata == 8'h00)
    else $error("reserved nonzero");
  a_read_idle_zero: assert property (@(posedge clk_sys) disable iff (rst)
    !req.rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");

  // Write path
  a_cfg1_write: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_4
    |=> ##1 ir_interface_config_one == $past(req.wdata, 2)) else $error("cfg1 write");
  a_pw_write: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && bank_reg == irb_pkg::BANK_6 && req.addr == irb_pkg::OFS_2
    |=> slow_ir_pulse_width_reg == ($past(req.wdata) & irb_pkg::MASK_PW)) else $error("pw write");
  a_ro_no_write: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_0
    |=> $stable(cfg_one_reg)) else $error("ro write leaked");

  // Shared UART bank flag
  a_uart_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (req.wr || req.rd) && !bank_reg[2] && req.addr != irb_pkg::OFS_3
    |=> uart_bank_access) else $error("shared bank flag missing");
  a_ir_bank_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    bank_reg[2]
    |=> !uart_bank_access) else $error("shared bank flag in IR bank");

  // Main scenarios
  c_bank7: cover property (@(posedge clk_sys) disable iff (rst) bank_reg == irb_pkg::BANK_7);
  c_bank6_pw: cover property (@(posedge clk_sys) disable iff (rst)
    req.wr && bank_reg == irb_pkg::BANK_6 && req.addr == irb_pkg::OFS_2);
  c_dma_both: cover property (@(posedge clk_sys) disable iff (rst) dma_reg == 2'h3);
  c_sel_clear: cover property (@(posedge clk_sys) disable iff (rst)
    wr_sel && !bank_mode);
  c_ro_read: cover property (@(posedge clk_sys) disable iff (rst)
    req.rd && bank_reg == irb_pkg::BANK_7 && req.addr == irb_pkg::OFS_0);

endmodule

// ===== irb_top_tb.sv
// Self-checking testbench for the infrared register bank
`timescale 1ns/1ns
module irb_top_tb;

  // Row of the ordinary case table: bank code, offset, write data, read-back
  typedef struct packed {
    logic [6:0] code;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } irb_row_type;

  localparam logic [6:0] K4 = irb_pkg::BANK_CODE_4;
  localparam logic [6:0] K5 = irb_pkg::BANK_CODE_5;
  localparam logic [6:0] K6 = irb_pkg::BANK_CODE_6;
  localparam logic [6:0] K7 = irb_pkg::BANK_CODE_7;

  // Clock, reset and ports
  logic                 clk_sys;
  logic                 rst;
  irb_pkg::irb_req_type req;
  logic           [7:0] rdata;
  irb_pkg::irb_ro_type  ro_in;
  logic           [2:0] active_bank;
  logic           [6:0] line_control;
  logic           [3:0] pulse_width_code;
  logic           [7:0] cfg_one;
  logic           [7:0] cfg_three;
  logic           [7:0] cfg_four;
  logic           [1:0] dma_channel_enable;
  logic                 uart_bank_access;
  // Bookkeeping
  int                   failures;
  int                   tests_run;
  logic           [7:0] rd_snap;
  logic                 ua_snap;
  irb_row_type          rows [0:16];
  logic           [6:0] bc [0:8];
  logic           [2:0] bk [0:8];

  irb_top uut
  (
    .clk_sys                   (clk_sys),
    .rst                       (rst),
    .req                       (req),
    .rdata                     (rdata),
    .ro_in                     (ro_in),
    .active_bank               (active_bank),
    .line_control              (line_control),
    .pulse_width_code          (pulse_width_code),
    .ir_interface_config_one   (cfg_one),
    .ir_interface_config_three (cfg_three),
    .ir_interface_config_four  (cfg_four),
    .dma_channel_enable        (dma_channel_enable),
    .uart_bank_access          (uart_bank_access)
  );

  // Clock at 10 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Answers that stand one cycle are caught mid-cycle, away from the edges
  always @(negedge clk_sys)
  begin
    rd_snap = rdata;
    ua_snap = uart_bank_access;
  end

  // Final verdict and end of run
  task automatic close_out;
    $display("checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One comparison with a report on mismatch
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One bus cycle, driven at the edge and taken at the next one
  task automatic cyc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clk_sys);
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 3'h0, 8'h00);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask

  // Read, then an idle cycle in which the answer stands
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b0, a, 8'h00);
    chk(rd_snap, exp, "read data");
  endtask

  task automatic sel(input logic [6:0] code);
    wr(3'h3, {1'b1, code});
  endtask

  // Watchdog at 3000 cycles, well beyond the expected run of about 140 cycles
  initial
  begin
    #(100 * 3000);
    failures++;
    $display("wrong value at %0t: run did not finish", $time);
    close_out();
  end

  // Main sequence
  initial
  begin
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    req = '0;
    ro_in = '{3'h5, 5'h0a, 3'h2, 5'h13, 8'h3c};
    rows = '{'{K4, 3'h2, 8'hff, irb_pkg::MASK_CTRL_ONE}, '{K4, 3'h0, 8'hff, 8'h00},
             '{K4, 3'h5, 8'hff, 8'h00}, '{K5, 3'h4, 8'hff, irb_pkg::MASK_CTRL_TWO},
             '{K5, 3'h1, 8'hff, 8'h00}, '{K6, 3'h0, 8'hff, irb_pkg::MASK_CTRL_THREE},
             '{K6, 3'h1, 8'hff, 8'h00}, '{K6, 3'h2, 8'hff, irb_pkg::MASK_PW},
             '{K6, 3'h6, 8'hff, 8'h00}, '{K6, 3'h3, 8'hf4, 8'hf4},
             '{K7, 3'h0, 8'hff, 8'haa}, '{K7, 3'h1, 8'hff, 8'h53},
             '{K7, 3'h2, 8'hff, 8'h3c}, '{K7, 3'h4, 8'ha5, 8'ha5},
             '{K7, 3'h5, 8'hff, 8'h00}, '{K7, 3'h6, 8'hff, irb_pkg::MASK_CFG_THREE},
             '{K7, 3'h7, 8'hff, irb_pkg::MASK_CFG_FOUR}};
    bc = '{7'h00, 7'h60, 7'h70, 7'h71, 7'h72, 7'h73, 7'h74, 7'h75, 7'h10};
    bk = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1};
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    idle(1);
    // Reset state and the shared-bank access flag
    chk({5'h00, active_bank}, 8'h00, "bank after reset");
    rd(3'h3, 8'h00);
    chk({7'h00, ua_snap}, 8'h00, "flag on selector");
    rd(3'h0, 8'h00);
    chk({7'h00, ua_snap}, 8'h01, "flag on bank 0");
    // Table of banked accesses, selector write followed at once by the access
    for (int i = 0; i < 17; i++)
    begin
      sel(rows[i].code);
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
      chk({7'h00, ua_snap}, 8'h00, "flag in IR bank");
    end
    idle(2);
    chk({4'h0, pulse_width_code}, 8'h0f, "pulse width");
    chk(cfg_one, 8'ha5, "config one");
    chk(cfg_three, 8'h77, "config three");
    chk(cfg_four, irb_pkg::MASK_CFG_FOUR, "config four");
    chk(rd_snap, 8'h00, "idle read data");
    // Every bank code, then a selector byte with the enable bit clear
    for (int i = 0; i < 9; i++)
    begin
      sel(bc[i]);
      idle(2);
      chk({5'h00, active_bank}, {5'h00, bk[i]}, "bank code");
    end
    wr(3'h3, 8'h75);
    idle(2);
    chk({5'h00, active_bank}, 8'h00, "enable clear");
    chk({1'b0, line_control}, 8'h75, "line control");
    rd(3'h3, 8'h75);
    // Channel enables, one and then both
    sel(K5);
    wr(3'h7, 8'hfe);
    idle(2);
    chk({6'h00, dma_channel_enable}, 8'h02, "one channel");
    wr(3'h7, 8'h03);
    idle(2);
    chk({6'h00, dma_channel_enable}, 8'h03, "both channels");
    // Status change passes through the synchroniser
    ro_in <= '{3'h3, 5'h1c, 3'h6, 5'h01, 8'hc3};
    sel(K7);
    idle(6);
    rd(3'h0, 8'h7c);
    rd(3'h1, 8'hc1);
    // Reset in mid-run clears bank and configuration
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    idle(1);
    chk({5'h00, active_bank}, 8'h00, "bank after reset");
    chk(cfg_one, 8'h00, "config after reset");
    chk({6'h00, dma_channel_enable}, 8'h00, "channels after reset");
    rd(3'h3, 8'h00);
    close_out();
  end

endmodule
